//--- synth_bias_config_regs.sv
/*
  Configuration bank at 04h..0Bh: second frequency word, separation,
  bias selects, analog pin mode, crystal bypass and output power.
  Assumes the serial front end delivers decoded one-cycle write and
  read strobes, and the main control register supplies its reset
  bit and frequency word select as levels.
*/
`timescale 1ns/1ps

module synth_bias_config_regs (
  input  wire logic                     MCLK_I,
  input  wire logic                     SRST_I,
  input  wire logic                     REG_RESET_N_I,
  input  wire logic                     FREQ_WORD_SEL_I,
  input  wire logic [23:0]              FIRST_FREQ_WORD_I,
  input  wire logic                     CFG_WE_I,
  input  wire synth_bias_pkg::cfg_write_t CFG_WR_I,
  input  wire logic                     CFG_RE_I,
  input  wire logic [6:0]               CFG_RADDR_I,
  output logic      [7:0]               CFG_RDATA_O,
  output logic      [23:0]              SECOND_FREQ_WORD_O,
  output logic      [23:0]              ACTIVE_FREQ_WORD_O,
  output logic      [10:0]              SEPARATION_O,
  output logic      [3:0]               OSC_CORE_BIAS_O,
  output logic      [1:0]               LOCAL_OSC_BUFFER_LEVEL_O,
  output logic      [1:0]               AMP_BUFFER_LEVEL_O,
  output logic                          AMP_FOLLOWER_STAGE_O,
  output logic      [1:0]               LOW_NOISE_AMP_BIAS_O,
  output logic      [1:0]               ANALOG_PIN_MODE_O,
  output synth_bias_pkg::pin_route_t    PIN_ROUTE_O,
  output logic                          CRYSTAL_OSC_OFF_O,
  output logic      [3:0]               HIGH_ARRAY_POWER_O,
  output logic      [3:0]               LOW_ARRAY_POWER_O
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic in_bank(input logic [6:0] addr);
    return (addr >= synth_bias_pkg::SECOND_FREQ_WORD_HIGH_ADDR) &&
           (addr <= synth_bias_pkg::OUTPUT_POWER_SETTING_ADDR);
  endfunction : in_bank

  function automatic logic [2:0] bank_index(input logic [6:0] addr);
    logic [6:0] diff;
    diff = addr - synth_bias_pkg::SECOND_FREQ_WORD_HIGH_ADDR;
    return diff[2:0];
  endfunction : bank_index

  logic [7:0] bank [synth_bias_pkg::NUM_REGS];
  logic       wr_hit;
  logic [2:0] wr_idx;
  logic       rd_hit;
  logic [2:0] rd_idx;
  logic [7:0] next_rdata;

  assign wr_hit     = CFG_WE_I && in_bank(CFG_WR_I.addr);
  assign wr_idx     = bank_index(CFG_WR_I.addr);
  assign rd_hit     = in_bank(CFG_RADDR_I);
  assign rd_idx     = bank_index(CFG_RADDR_I);
  assign next_rdata = rd_hit ? bank[rd_idx] : 8'h00;

  // ---------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------
  // per-byte storage with defaults
  for (genvar g = 0; g < synth_bias_pkg::NUM_REGS; g++) begin : g_reg
    cfg_byte_reg #(
      .RESET_VAL (synth_bias_pkg::REG_RESET[g]),
      .MASK      (synth_bias_pkg::REG_MASK[g])
    ) u_reg (
      .clk_i         (MCLK_I),
      .srst_i        (SRST_I),
      .reg_reset_n_i (REG_RESET_N_I),
      .we_i          (wr_hit && (wr_idx == 3'(g))),
      .wdata_i       (CFG_WR_I.data),
      .q_o           (bank[g])
    );
  end

  // ---------------------------------------------------------------
  // Field views
  // ---------------------------------------------------------------
  logic [7:0] bias_reg;
  logic [7:0] path_reg;
  logic [7:0] power_reg;
  logic [1:0] pin_mode;
  logic [23:0] second_word;
  logic [23:0] next_active;
  synth_bias_pkg::pin_route_t next_route;

  assign bias_reg    = bank[synth_bias_pkg::IDX_BIAS];
  assign path_reg    = bank[synth_bias_pkg::IDX_RX_PATH];
  assign power_reg   = bank[synth_bias_pkg::IDX_POWER];
  assign pin_mode    = path_reg[synth_bias_pkg::PIN_MODE_LSB +: 2];
  assign second_word = {bank[synth_bias_pkg::IDX_FREQ_HIGH],
                        bank[synth_bias_pkg::IDX_FREQ_MID],
                        bank[synth_bias_pkg::IDX_FREQ_LOW]};
  assign next_active = FREQ_WORD_SEL_I ? second_word : FIRST_FREQ_WORD_I;

  // pin mode decode; code 11 routes nothing
  assign next_route.internal_if_on  = (pin_mode == synth_bias_pkg::PIN_INTERNAL_PATH) ||
                                      (pin_mode == synth_bias_pkg::PIN_SIGNAL_LEVEL);
  assign next_route.signal_level_on = (pin_mode == synth_bias_pkg::PIN_SIGNAL_LEVEL);
  assign next_route.mixer_out_on    = (pin_mode == synth_bias_pkg::PIN_MIXER_OUT);

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      CFG_RDATA_O        <= 8'h00;
      ACTIVE_FREQ_WORD_O <= 24'h000000;
      PIN_ROUTE_O        <= '0;
    end else begin
      if (CFG_RE_I) begin
        CFG_RDATA_O <= next_rdata;
      end
      ACTIVE_FREQ_WORD_O <= next_active;
      PIN_ROUTE_O        <= next_route;
    end
  end

  // Field outputs are direct slices of the bank flip-flops
  assign SECOND_FREQ_WORD_O       = second_word;
  assign SEPARATION_O             = {bank[synth_bias_pkg::IDX_SEP_HIGH][2:0],
                                     bank[synth_bias_pkg::IDX_SEP_LOW]};
  assign OSC_CORE_BIAS_O          = bias_reg[synth_bias_pkg::OSC_CORE_BIAS_LSB +: 4];
  assign LOCAL_OSC_BUFFER_LEVEL_O = bias_reg[synth_bias_pkg::LOCAL_OSC_BUF_LSB +: 2];
  assign AMP_BUFFER_LEVEL_O       = bias_reg[synth_bias_pkg::AMP_BUF_LSB +: 2];
  assign AMP_FOLLOWER_STAGE_O     = path_reg[synth_bias_pkg::FOLLOWER_BIT];
  assign LOW_NOISE_AMP_BIAS_O     = path_reg[synth_bias_pkg::LNA_BIAS_LSB +: 2];
  assign ANALOG_PIN_MODE_O        = pin_mode;
  assign CRYSTAL_OSC_OFF_O        = path_reg[synth_bias_pkg::XOSC_OFF_BIT];
  // host keeps this zero in power-down; stored as written
  assign HIGH_ARRAY_POWER_O       = power_reg[synth_bias_pkg::HIGH_ARRAY_LSB +: 4];
  assign LOW_ARRAY_POWER_O        = power_reg[synth_bias_pkg::LOW_ARRAY_LSB +: 4];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic reset_any;
  assign reset_any = SRST_I || !REG_RESET_N_I;

  property p_freq_defaults;
    @(posedge MCLK_I) disable iff (SRST_I)
      !REG_RESET_N_I |=> (SECOND_FREQ_WORD_O == 24'h75a54e);
  endproperty
  a_freq_defaults: assert property (p_freq_defaults) else $error("second word default wrong");

  property p_sep_defaults;
    @(posedge MCLK_I) disable iff (SRST_I)
      !REG_RESET_N_I |=> (SEPARATION_O == 11'h059);
  endproperty
  a_sep_defaults: assert property (p_sep_defaults) else $error("separation default wrong");

  property p_bias_defaults;
    @(posedge MCLK_I) disable iff (SRST_I)
      !REG_RESET_N_I |=> (OSC_CORE_BIAS_O == 4'hc) && (LOCAL_OSC_BUFFER_LEVEL_O == 2'h2) &&
                         (AMP_BUFFER_LEVEL_O == 2'h2);
  endproperty
  a_bias_defaults: assert property (p_bias_defaults) else $error("bias default wrong");

  property p_path_defaults;
    @(posedge MCLK_I) disable iff (SRST_I)
      !REG_RESET_N_I |=> !AMP_FOLLOWER_STAGE_O && (LOW_NOISE_AMP_BIAS_O == 2'h1) &&
                         (ANALOG_PIN_MODE_O == 2'h0) && !CRYSTAL_OSC_OFF_O;
  endproperty
  a_path_defaults: assert property (p_path_defaults) else $error("front path default wrong");

  property p_power_defaults;
    @(posedge MCLK_I) disable iff (SRST_I)
      !REG_RESET_N_I |=> (HIGH_ARRAY_POWER_O == 4'h0) && (LOW_ARRAY_POWER_O == 4'hf);
  endproperty
  a_power_defaults: assert property (p_power_defaults) else $error("power default wrong");

  property p_write_word_high;
    @(posedge MCLK_I) disable iff (reset_any)
      (CFG_WE_I && CFG_WR_I.addr == 7'h04) ##1 !reset_any
      |-> (SECOND_FREQ_WORD_O[23:16] == $past(CFG_WR_I.data));
  endproperty
  a_write_word_high: assert property (p_write_word_high) else $error("word high not written");

  property p_sep_top_zero;
    @(posedge MCLK_I) disable iff (SRST_I)
      (CFG_RE_I && CFG_RADDR_I == 7'h07) |=> (CFG_RDATA_O[7:3] == 5'h00);
  endproperty
  a_sep_top_zero: assert property (p_sep_top_zero) else $error("unused separation bits nonzero");

  property p_path_top_zero;
    @(posedge MCLK_I) disable iff (SRST_I)
      (CFG_RE_I && CFG_RADDR_I == 7'h0a) |=> (CFG_RDATA_O[7:6] == 2'h0);
  endproperty
  a_path_top_zero: assert property (p_path_top_zero) else $error("unused path bits nonzero");

  property p_unmapped_zero;
    @(posedge MCLK_I) disable iff (SRST_I)
      (CFG_RE_I && (CFG_RADDR_I < 7'h04 || CFG_RADDR_I > 7'h0b)) |=> (CFG_RDATA_O == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

  property p_hold;
    @(posedge MCLK_I) disable iff (reset_any)
      !CFG_WE_I ##1 !reset_any |-> $stable(SECOND_FREQ_WORD_O) && $stable(SEPARATION_O) &&
                                   $stable(LOW_ARRAY_POWER_O) && $stable(HIGH_ARRAY_POWER_O);
  endproperty
  a_hold: assert property (p_hold) else $error("field changed without write");

  property p_active_word;
    @(posedge MCLK_I) disable iff (SRST_I)
      FREQ_WORD_SEL_I |=> (ACTIVE_FREQ_WORD_O == $past(SECOND_FREQ_WORD_O));
  endproperty
  a_active_word: assert property (p_active_word) else $error("second word not selected");

  property p_first_word;
    @(posedge MCLK_I) disable iff (SRST_I)
      !FREQ_WORD_SEL_I |=> (ACTIVE_FREQ_WORD_O == $past(FIRST_FREQ_WORD_I));
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word not selected");

  property p_mixer_mode;
    @(posedge MCLK_I) disable iff (SRST_I)
      (ANALOG_PIN_MODE_O == 2'h2) |=> PIN_ROUTE_O.mixer_out_on && !PIN_ROUTE_O.internal_if_on;
  endproperty
  a_mixer_mode: assert property (p_mixer_mode) else $error("mixer mode route wrong");

  property p_xosc_write;
    @(posedge MCLK_I) disable iff (reset_any)
      (CFG_WE_I && CFG_WR_I.addr == 7'h0a) ##1 !reset_any
      |-> (CRYSTAL_OSC_OFF_O == $past(CFG_WR_I.data[0]));
  endproperty
  a_xosc_write: assert property (p_xosc_write) else $error("crystal bypass not written");

  property p_write_sep_high;
    @(posedge MCLK_I) disable iff (reset_any)
      (CFG_WE_I && CFG_WR_I.addr == 7'h07) ##1 !reset_any
      |-> (SEPARATION_O[10:8] == $past(CFG_WR_I.data[2:0]));
  endproperty
  a_write_sep_high: assert property (p_write_sep_high) else $error("separation top not written");

  property p_write_sep_low;
    @(posedge MCLK_I) disable iff (reset_any)
      (CFG_WE_I && CFG_WR_I.addr == 7'h08) ##1 !reset_any
      |-> (SEPARATION_O[7:0] == $past(CFG_WR_I.data));
  endproperty
  a_write_sep_low: assert property (p_write_sep_low) else $error("separation low not written");

  property p_write_bias;
    @(posedge MCLK_I) disable iff (reset_any)
      (CFG_WE_I && CFG_WR_I.addr == 7'h09) ##1 !reset_any
      |-> ({OSC_CORE_BIAS_O, LOCAL_OSC_BUFFER_LEVEL_O, AMP_BUFFER_LEVEL_O} == $past(CFG_WR_I.data));
  endproperty
  a_write_bias: assert property (p_write_bias) else $error("bias fields not written");

  property p_write_path;
    @(posedge MCLK_I) disable iff (reset_any)
      (CFG_WE_I && CFG_WR_I.addr == 7'h0a) ##1 !reset_any
      |-> ({AMP_FOLLOWER_STAGE_O, LOW_NOISE_AMP_BIAS_O, ANALOG_PIN_MODE_O, CRYSTAL_OSC_OFF_O} == $past(CFG_WR_I.data[5:0]));
  endproperty
  a_write_path: assert property (p_write_path) else $error("front path fields not written");

  property p_write_power;
    @(posedge MCLK_I) disable iff (reset_any)
      (CFG_WE_I && CFG_WR_I.addr == 7'h0b) ##1 !reset_any
      |-> ({HIGH_ARRAY_POWER_O, LOW_ARRAY_POWER_O} == $past(CFG_WR_I.data));
  endproperty
  a_write_power: assert property (p_write_power) else $error("power fields not written");

  property p_read_word_high;
    @(posedge MCLK_I) disable iff (SRST_I)
      (CFG_RE_I && CFG_RADDR_I == 7'h04) |=> (CFG_RDATA_O == $past(SECOND_FREQ_WORD_O[23:16]));
  endproperty
  a_read_word_high: assert property (p_read_word_high) else $error("word high read wrong");

  property p_rdata_hold;
    @(posedge MCLK_I) disable iff (SRST_I)
      !CFG_RE_I |=> $stable(CFG_RDATA_O);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");

  property p_route_signal;
    @(posedge MCLK_I) disable iff (SRST_I)
      (ANALOG_PIN_MODE_O == 2'h1) |=> PIN_ROUTE_O.signal_level_on && PIN_ROUTE_O.internal_if_on &&
                                      !PIN_ROUTE_O.mixer_out_on;
  endproperty
  a_route_signal: assert property (p_route_signal) else $error("signal level route wrong");

  property p_route_none;
    @(posedge MCLK_I) disable iff (SRST_I)
      (ANALOG_PIN_MODE_O == 2'h3) |=> (PIN_ROUTE_O == 3'h0);
  endproperty
  a_route_none: assert property (p_route_none) else $error("unused mode route not off");

  c_reg_reset:  cover property (@(posedge MCLK_I) disable iff (SRST_I) !REG_RESET_N_I ##1 REG_RESET_N_I);
  c_power_zero: cover property (@(posedge MCLK_I) disable iff (SRST_I)
                                CFG_WE_I && CFG_WR_I.addr == 7'h0b && CFG_WR_I.data == 8'h00);
  c_sel_second: cover property (@(posedge MCLK_I) disable iff (SRST_I) !FREQ_WORD_SEL_I ##1 FREQ_WORD_SEL_I);
  c_signal_pin: cover property (@(posedge MCLK_I) disable iff (SRST_I) PIN_ROUTE_O.signal_level_on);

endmodule : synth_bias_config_regs

//--- synth_bias_pkg.sv
/*
  Shared constants and carrier types for the second frequency word,
  separation, bias and output power configuration bank.
  Assumes an 8-bit register port with 7-bit addresses, as delivered
  by the serial configuration front end.
*/
package synth_bias_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 8;
  localparam int NUM_REGS = 8;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] SECOND_FREQ_WORD_HIGH_ADDR = 7'h04;
  localparam logic [6:0] SECOND_FREQ_WORD_MID_ADDR  = 7'h05;
  localparam logic [6:0] SECOND_FREQ_WORD_LOW_ADDR  = 7'h06;
  localparam logic [6:0] SEPARATION_HIGH_ADDR       = 7'h07;
  localparam logic [6:0] SEPARATION_LOW_ADDR        = 7'h08;
  localparam logic [6:0] BIAS_CURRENT_SELECT_ADDR   = 7'h09;
  localparam logic [6:0] RECEIVE_PATH_CONTROL_ADDR  = 7'h0a;
  localparam logic [6:0] OUTPUT_POWER_SETTING_ADDR  = 7'h0b;

  // Bank indices, offset minus the first address
  localparam int IDX_FREQ_HIGH = 0;
  localparam int IDX_FREQ_MID  = 1;
  localparam int IDX_FREQ_LOW  = 2;
  localparam int IDX_SEP_HIGH  = 3;
  localparam int IDX_SEP_LOW   = 4;
  localparam int IDX_BIAS      = 5;
  localparam int IDX_RX_PATH   = 6;
  localparam int IDX_POWER     = 7;

  // ---------------------------------------------------------------
  // Values after reset and writable-bit masks, by bank index
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    8'h75, 8'ha5, 8'h4e, 8'h00, 8'h59, 8'hca, 8'h08, 8'h0f
  };
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{
    8'hff, 8'hff, 8'hff, 8'h07, 8'hff, 8'hff, 8'h3f, 8'hff
  };

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int OSC_CORE_BIAS_LSB    = 4;
  localparam int LOCAL_OSC_BUF_LSB    = 2;
  localparam int AMP_BUF_LSB          = 0;
  localparam int FOLLOWER_BIT         = 5;
  localparam int LNA_BIAS_LSB         = 3;
  localparam int PIN_MODE_LSB         = 1;
  localparam int XOSC_OFF_BIT         = 0;
  localparam int HIGH_ARRAY_LSB       = 4;
  localparam int LOW_ARRAY_LSB        = 0;

  // Analog pin modes
  localparam logic [1:0] PIN_INTERNAL_PATH = 2'h0;
  localparam logic [1:0] PIN_SIGNAL_LEVEL  = 2'h1;
  localparam logic [1:0] PIN_MIXER_OUT     = 2'h2;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } cfg_write_t;

  typedef struct packed {
    logic internal_if_on;
    logic signal_level_on;
    logic mixer_out_on;
  } pin_route_t;

endpackage : synth_bias_pkg

//--- cfg_byte_reg.sv
/*
  One 8-bit configuration register with a value after reset and a
  mask of implemented bits.
  Assumes a single clock; both resets are synchronous.
*/
`timescale 1ns/1ps
module cfg_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] MASK      = 8'hff
) (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       reg_reset_n_i,
  input  wire logic       we_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] q_o
);

  logic [7:0] next_q;

  // Register reset wins over a write in the same cycle
  assign next_q = (srst_i || !reg_reset_n_i) ? RESET_VAL :
                  we_i                        ? (wdata_i & MASK) :
                                                q_o;

  always_ff @(posedge clk_i) begin
    q_o <= next_q;
  end

endmodule : cfg_byte_reg

//--- host_cfg_model.sv
/*
  Host model: drives the decoded register write and read strobes.
  Assumes calls start just after a rising clock edge.
*/
`timescale 1ns/1ps
module host_cfg_model (
  input  wire logic                   clk_i,
  output logic                        we_o,
  output synth_bias_pkg::cfg_write_t  wr_o,
  output logic                        re_o,
  output logic [6:0]                  raddr_o,
  input  wire logic [7:0]             rdata_i
);
  initial begin
    we_o = 1'b0;
    wr_o = '0;
    re_o = 1'b0;
    raddr_o = 7'h00;
  end

  // Released lines show the inverse, not the last value
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    we_o = 1'b1;
    wr_o = {addr, data};
    @(posedge clk_i);
    #1;
    we_o = 1'b0;
    wr_o = ~wr_o;
    @(posedge clk_i);
    #1;
  endtask : write_reg

  task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
    re_o = 1'b1;
    raddr_o = addr;
    @(posedge clk_i);
    #1;
    re_o = 1'b0;
    raddr_o = ~raddr_o;
    data = rdata_i;
    @(posedge clk_i);
    #1;
  endtask : read_reg

  task automatic power_down();
    write_reg(7'h0b, 8'h00);
  endtask : power_down
endmodule : host_cfg_model

//--- synth_bias_config_regs_tb.sv
/*
  Self-checking bench for the configuration bank, compared with an
  integer register model. Assumes the host model file is compiled first.
*/
`timescale 1ns/1ps
module synth_bias_config_regs_tb;
  localparam int CEILING = 6000;
  logic                       mclk, srst, reg_reset_n, sel, we, re, fol, xosc;
  logic [23:0]                first_word, second, active;
  synth_bias_pkg::cfg_write_t wr;
  synth_bias_pkg::pin_route_t route;
  logic [6:0]                 raddr;
  logic [7:0]                 rdata, rd;
  logic [10:0]                sep;
  logic [3:0]                 osc, high, low;
  logic [1:0]                 lob, amp, lna, pin;
  int                         n_errors, n_tests, cycles, ref_regs[8];
  int                         route_tab[4] = '{4, 6, 1, 0};
  logic [31:0]                seed;

  host_cfg_model u_host (.clk_i(mclk), .we_o(we), .wr_o(wr), .re_o(re), .raddr_o(raddr), .rdata_i(rdata));

  synth_bias_config_regs u_dut (
    .MCLK_I(mclk), .SRST_I(srst), .REG_RESET_N_I(reg_reset_n), .FREQ_WORD_SEL_I(sel),
    .FIRST_FREQ_WORD_I(first_word), .CFG_WE_I(we), .CFG_WR_I(wr), .CFG_RE_I(re),
    .CFG_RADDR_I(raddr), .CFG_RDATA_O(rdata), .SECOND_FREQ_WORD_O(second),
    .ACTIVE_FREQ_WORD_O(active), .SEPARATION_O(sep), .OSC_CORE_BIAS_O(osc),
    .LOCAL_OSC_BUFFER_LEVEL_O(lob), .AMP_BUFFER_LEVEL_O(amp), .AMP_FOLLOWER_STAGE_O(fol),
    .LOW_NOISE_AMP_BIAS_O(lna), .ANALOG_PIN_MODE_O(pin), .PIN_ROUTE_O(route),
    .CRYSTAL_OSC_OFF_O(xosc), .HIGH_ARRAY_POWER_O(high), .LOW_ARRAY_POWER_O(low));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ref_reset();
    for (int i = 0; i < 8; i++) begin
      ref_regs[i] = synth_bias_pkg::REG_RESET[i];
    end
  endtask : ref_reset

  task automatic ref_write(input int addr, input int data);
    if (addr >= 4 && addr <= 11) begin
      ref_regs[addr-4] = data & synth_bias_pkg::REG_MASK[addr-4];
    end
  endtask : ref_write

  function automatic int ref_read(input int addr);
    return (addr >= 4 && addr <= 11) ? ref_regs[addr-4] : 0;
  endfunction : ref_read

  task automatic wr_both(input logic [6:0] addr, input logic [7:0] data);
    u_host.write_reg(addr, data);
    ref_write(addr, data);
  endtask : wr_both

  task automatic rd_check(input logic [6:0] addr);
    u_host.read_reg(addr, rd);
    check(rd, ref_read(addr));
  endtask : rd_check

  task automatic check_fields();
    int exp_second;
    exp_second = (ref_regs[0] << 16) | (ref_regs[1] << 8) | ref_regs[2];
    check(second, exp_second);
    check(active, sel ? exp_second : first_word);
    check(sep, ((ref_regs[3] & 7) << 8) | ref_regs[4]);
    check(osc, ref_regs[5] >> 4);
    check(lob, (ref_regs[5] >> 2) & 3);
    check(amp, ref_regs[5] & 3);
    check(fol, (ref_regs[6] >> 5) & 1);
    check(lna, (ref_regs[6] >> 3) & 3);
    check(pin, (ref_regs[6] >> 1) & 3);
    check(route, route_tab[(ref_regs[6] >> 1) & 3]);
    check(xosc, ref_regs[6] & 1);
    check(high, ref_regs[7] >> 4);
    check(low, ref_regs[7] & 15);
  endtask : check_fields

  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // Clock and timeout
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == CEILING) begin
      n_errors++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    srst = 1'b1;
    reg_reset_n = 1'b1;
    sel = 1'b0;
    first_word = 24'h000000;
    seed = 32'h00000016;
    repeat (16) @(posedge mclk);
    #1;
    srst = 1'b0;
    ref_reset();
    @(posedge mclk);
    #1;
    check_fields();
    for (int a = 0; a < 16; a++) begin
      rd_check(a[6:0]);
    end
    $display("test defaults done");

    repeat (200) begin
      sel = 1'(xorshift() & 32'h1);
      first_word = 24'(xorshift());
      wr_both((xorshift() & 1) ? 7'(4 + xorshift() % 8) : 7'(xorshift()), 8'(xorshift()));
      check_fields();
      rd_check((xorshift() & 1) ? 7'(4 + xorshift() % 8) : 7'(xorshift()));
    end
    $display("test random access done");

    for (int m = 0; m < 4; m++) begin
      wr_both(7'h0a, 8'(32'hc0 | (m << 1) | (m & 1)));
      check_fields();
      rd_check(7'h0a);
    end
    $display("test pin modes done");

    reg_reset_n = 1'b0;
    u_host.write_reg(7'h04, 8'hff);
    reg_reset_n = 1'b1;
    ref_reset();
    check_fields();
    for (int a = 4; a < 12; a++) begin
      rd_check(a[6:0]);
    end
    $display("test register reset done");

    u_host.power_down();
    ref_write(11, 0);
    check_fields();
    rd_check(7'h0b);
    $display("test power down done");
    stop_test();
  end
endmodule : synth_bias_config_regs_tb
